// File: hdl/dsfcp_top.sv
// dual-slope frequency-correct pwm timer with apb register access
`timescale 1ns/1ps
module dsfcp_top import dsfcp_pkg::*; (
   input wire logic mclk,
   input wire logic reset_n,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   output logic [NUM_CH-1:0] compareOut,
   output logic [NUM_CH-1:0] compareOe
);
   logic [3:0] waveformModeSel;
   dsfcp_clksel_e clkSel;
   dsfcp_action_e outputActionSel [NUM_CH];
   logic [CNT_W-1:0] compareBuf [NUM_CH];
   logic [CNT_W-1:0] captureValue;
   logic [NUM_CH-1:0] pinDirectionBit;
   logic [3:0] flags;
   logic [CNT_W-1:0] countValue;
   dsfcp_dir_e dir;
   logic timerTick;
   logic pfcMode;
   logic [CNT_W-1:0] topValue;
   logic upPhase;
   logic bottomHit;
   logic topHit;
   logic [3:0] flagSet;
   logic [3:0] flagClr;
   logic apbSetup;
   logic apbWrite;
   logic addrOk;
   logic [31:0] rdMux;
   logic [NUM_CH-1:0] cmpMatch;
   logic [NUM_CH-1:0] chanLvl;
   logic [CNT_W-1:0] activeA;

   dsfcp_cmp_if cmpBus [NUM_CH] ();

   dsfcp_prescaler u_prescaler (
      .mclk(mclk),
      .reset_n(reset_n),
      .clkSel(clkSel),
      .tick(timerTick)
   );

   generate
      for (genvar g = 0; g < NUM_CH; g++)
      begin : g_chan
         assign cmpBus[g].tick = timerTick && pfcMode;
         assign cmpBus[g].upPhase = upPhase;
         assign cmpBus[g].load = bottomHit || !pfcMode;
         assign cmpBus[g].isChanA = (g == 0);
         assign cmpBus[g].count = countValue;
         assign cmpBus[g].top = topValue;
         assign cmpBus[g].bufVal = compareBuf[g];
         assign cmpBus[g].action = outputActionSel[g];
         assign cmpMatch[g] = cmpBus[g].match;
         assign chanLvl[g] = cmpBus[g].outLvl;
         assign compareOut[g] = chanLvl[g];

         dsfcp_channel u_channel (
            .mclk(mclk),
            .reset_n(reset_n),
            .cb(cmpBus[g])
         );

         // action 1 on channel b is reserved, so its pin stays released
         always_ff @(posedge mclk)
         begin
            if (!reset_n)
               compareOe[g] <= 1'b0;
            else
               compareOe[g] <= pinDirectionBit[g] && outputActionSel[g] != ACT_OFF &&
                  !(g != 0 && outputActionSel[g] == ACT_TOGGLE);
         end
      end
   endgenerate

   assign activeA = cmpBus[0].activeVal;

   // counter core
   assign pfcMode = waveformModeSel == MODE_PFC_CAPT || waveformModeSel == MODE_PFC_CMPA;
   // mode 9 follows the double-buffered compare a, so a live top change is clean
   assign topValue = (waveformModeSel == MODE_PFC_CMPA) ? activeA : captureValue;

   // bottom counts as up-slope and top as down-slope, so the extremes hold a level
   assign upPhase = countValue == BOTTOM || (dir == DIR_UP && countValue != topValue);

   assign bottomHit = pfcMode && timerTick && dir == DIR_DOWN && countValue == 16'h0001;
   assign topHit = pfcMode && timerTick && dir == DIR_UP && countValue == CNT_W'(topValue - 1'b1);

   // relies on software keeping top at or above TOP_MIN
   always_ff @(posedge mclk)
   begin
      if (!reset_n || !pfcMode)
      begin
         countValue <= CNT_RST;
         dir <= DIR_UP;
      end
      else if (timerTick)
      begin
         case (dir)
            DIR_UP:
            begin
               if (countValue >= topValue)
               begin
                  countValue <= CNT_W'(countValue - 1'b1);
                  dir <= DIR_DOWN;
               end
               else
                  countValue <= CNT_W'(countValue + 1'b1);
            end
            DIR_DOWN:
            begin
               if (countValue == BOTTOM)
               begin
                  countValue <= CNT_W'(countValue + 1'b1);
                  dir <= DIR_UP;
               end
               else
                  countValue <= CNT_W'(countValue - 1'b1);
            end
            default:
            begin
               countValue <= CNT_RST;
               dir <= DIR_UP;
            end
         endcase
      end
   end

   // flags: hardware set wins over a software clear in the same cycle
   assign flagSet[FLAG_OVF] = bottomHit;
   assign flagSet[FLAG_CMPA] = cmpMatch[0] || (topHit && waveformModeSel == MODE_PFC_CMPA);
   assign flagSet[FLAG_CMPB] = cmpMatch[1];
   assign flagSet[FLAG_CAPT] = topHit && waveformModeSel == MODE_PFC_CAPT;
   assign flagClr = (apbWrite && paddr == OFS_FLAGS) ? pwdata[3:0] : 4'h0;

   always_ff @(posedge mclk)
   begin
      if (!reset_n)
         flags <= FLAGS_RST;
      else
         flags <= (flags & ~flagClr) | flagSet;
   end

   // apb slave: one wait-free access phase, ready registered from the setup cycle
   assign apbSetup = psel && !penable;
   assign apbWrite = psel && penable && pwrite && pready && !pslverr;

   always_comb
   begin
      addrOk = 1'b1;
      rdMux = 32'h0000_0000;
      case (paddr)
         OFS_CTRL:
         begin
            rdMux[CTRL_MODE_LSB +: 4] = waveformModeSel;
            rdMux[CTRL_CLK_LSB +: 3] = clkSel;
            rdMux[CTRL_ACTA_LSB +: 2] = outputActionSel[0];
            rdMux[CTRL_ACTB_LSB +: 2] = outputActionSel[1];
         end
         OFS_COUNT: rdMux[CNT_W-1:0] = countValue;
         OFS_CMPA: rdMux[CNT_W-1:0] = compareBuf[0];
         OFS_CMPB: rdMux[CNT_W-1:0] = compareBuf[1];
         OFS_CAPT: rdMux[CNT_W-1:0] = captureValue;
         OFS_FLAGS: rdMux[3:0] = flags;
         OFS_PINDIR: rdMux[NUM_CH-1:0] = pinDirectionBit;
         default: addrOk = 1'b0;
      endcase
   end

   always_ff @(posedge mclk)
   begin
      if (!reset_n)
      begin
         pready <= 1'b0;
         pslverr <= 1'b0;
         prdata <= 32'h0000_0000;
      end
      else
      begin
         pready <= apbSetup;
         pslverr <= apbSetup && !addrOk;
         if (apbSetup)
            prdata <= pwrite ? 32'h0000_0000 : rdMux;
      end
   end

   always_ff @(posedge mclk)
   begin
      if (!reset_n)
      begin
         waveformModeSel <= 4'h0;
         clkSel <= CS_STOP;
         outputActionSel[0] <= ACT_OFF;
         outputActionSel[1] <= ACT_OFF;
      end
      else if (apbWrite && paddr == OFS_CTRL)
      begin
         waveformModeSel <= pwdata[CTRL_MODE_LSB +: 4];
         clkSel <= dsfcp_clksel_e'(pwdata[CTRL_CLK_LSB +: 3]);
         outputActionSel[0] <= dsfcp_action_e'(pwdata[CTRL_ACTA_LSB +: 2]);
         outputActionSel[1] <= dsfcp_action_e'(pwdata[CTRL_ACTB_LSB +: 2]);
      end
   end

   // compare writes only reach the buffer; the channel loads it at bottom, and on every cycle outside modes 8 and 9
   always_ff @(posedge mclk)
   begin
      if (!reset_n)
      begin
         compareBuf[0] <= CNT_RST;
         compareBuf[1] <= CNT_RST;
      end
      else if (apbWrite && paddr == OFS_CMPA)
         compareBuf[0] <= pwdata[CNT_W-1:0];
      else if (apbWrite && paddr == OFS_CMPB)
         compareBuf[1] <= pwdata[CNT_W-1:0];
   end

   // capture value is not buffered: a live change may break symmetry
   always_ff @(posedge mclk)
   begin
      if (!reset_n)
         captureValue <= CNT_RST;
      else if (apbWrite && paddr == OFS_CAPT)
         captureValue <= pwdata[CNT_W-1:0];
   end

   always_ff @(posedge mclk)
   begin
      if (!reset_n)
         pinDirectionBit <= '0;
      else if (apbWrite && paddr == OFS_PINDIR)
         pinDirectionBit <= pwdata[NUM_CH-1:0];
   end

   default clocking dclk @(posedge mclk);
   endclocking
   default disable iff (!reset_n);

   a_idle_mode: assert property (!pfcMode |=> countValue == BOTTOM && dir == DIR_UP)
      else $error("counter not parked outside pwm mode");
   a_count_up: assert property (pfcMode && timerTick && dir == DIR_UP
      && countValue < topValue ##1 pfcMode |-> countValue == CNT_W'($past(countValue) + 1'b1))
      else $error("up-count step wrong");
   a_top_turn: assert property (pfcMode && timerTick && dir == DIR_UP
      && countValue == topValue ##1 pfcMode |-> dir == DIR_DOWN && countValue == CNT_W'($past(countValue) - 1'b1))
      else $error("no reversal at top");
   a_top_dwell: assert property (topHit ##1 (pfcMode && !timerTick)
      |=> countValue == CNT_W'($past(countValue, 2) + 1'b1))
      else $error("count left top before a tick");
   a_ovf_bottom: assert property (bottomHit |=> flags[FLAG_OVF] && countValue == BOTTOM)
      else $error("overflow flag not set at bottom");
   a_capt_top: assert property (topHit && waveformModeSel == MODE_PFC_CAPT |=> flags[FLAG_CAPT])
      else $error("capture flag not set at top");
   a_cmpb_flag: assert property (cmpMatch[1] && flagClr[FLAG_CMPB] |=> flags[FLAG_CMPB])
      else $error("compare b flag lost against a clear");
   a_pin_enable: assert property (##1 compareOe[0] == ($past(pinDirectionBit[0]) &&
      $past(outputActionSel[0]) != ACT_OFF))
      else $error("pin enable a wrong");
   a_apb_ready: assert property (apbSetup |=> pready ##1 !pready)
      else $error("apb ready not one cycle after setup");

   // slope ends, tick gating, flag sources and the second pin are checked apart from the up-slope
   a_count_down: assert property (pfcMode && timerTick && dir == DIR_DOWN
      && countValue != BOTTOM ##1 pfcMode |-> countValue == CNT_W'($past(countValue) - 1'b1))
      else $error("down-count step wrong");
   a_bottom_turn: assert property (pfcMode && timerTick && dir == DIR_DOWN
      && countValue == BOTTOM ##1 pfcMode |-> dir == DIR_UP && countValue == 16'h0001)
      else $error("no reversal at bottom");
   a_tick_hold: assert property (
      pfcMode && !timerTick |=> $stable(countValue) && $stable(dir))
      else $error("count moved without a timer tick");
   a_cmpa_flag: assert property (
      cmpMatch[0] |=> flags[FLAG_CMPA])
      else $error("compare a flag not set on match");
   a_cmpa_top: assert property (
      topHit && waveformModeSel == MODE_PFC_CMPA |=> flags[FLAG_CMPA])
      else $error("compare a flag not set at top");
   a_load_bottom: assert property (
      bottomHit |=> activeA == $past(compareBuf[0]))
      else $error("compare a not loaded at bottom");
   a_pin_enable_b: assert property (##1 compareOe[1] == ($past(pinDirectionBit[1]) &&
      $past(outputActionSel[1]) != ACT_OFF && $past(outputActionSel[1]) != ACT_TOGGLE))
      else $error("pin enable b wrong");
   a_ready_err: assert property (
      pslverr |-> pready)
      else $error("slave error without ready");
   a_flag_clear: assert property (
      flagClr[FLAG_OVF] && !bottomHit |=> !flags[FLAG_OVF])
      else $error("overflow flag not cleared by write");
   a_capt_mode9: assert property (
      waveformModeSel == MODE_PFC_CMPA |-> !flagSet[FLAG_CAPT])
      else $error("capture flag source active in mode 9");

   c_bottom: cover property (bottomHit);
   c_top_cmpa: cover property (topHit && waveformModeSel == MODE_PFC_CMPA);
   c_out_rise: cover property (!compareOut[0] ##1 compareOut[0]);
   c_flag_clear: cover property (flags[FLAG_OVF] && flagClr[FLAG_OVF] && !bottomHit);
endmodule : dsfcp_top

// File: inc/dsfcp_pkg.sv
// constants and types of the dual-slope frequency-correct pwm timer
package dsfcp_pkg;
   localparam int CNT_W = 16;
   localparam int NUM_CH = 2;
   localparam int DIV_W = 10;
   localparam logic [7:0] OFS_CTRL = 8'h00;
   localparam logic [7:0] OFS_COUNT = 8'h04;
   localparam logic [7:0] OFS_CMPA = 8'h08;
   localparam logic [7:0] OFS_CMPB = 8'h0C;
   localparam logic [7:0] OFS_CAPT = 8'h10;
   localparam logic [7:0] OFS_FLAGS = 8'h14;
   localparam logic [7:0] OFS_PINDIR = 8'h18;
   localparam int CTRL_MODE_LSB = 0;
   localparam int CTRL_CLK_LSB = 4;
   localparam int CTRL_ACTA_LSB = 8;
   localparam int CTRL_ACTB_LSB = 10;
   localparam int FLAG_OVF = 0;
   localparam int FLAG_CMPA = 1;
   localparam int FLAG_CMPB = 2;
   localparam int FLAG_CAPT = 3;
   localparam logic [3:0] MODE_PFC_CAPT = 4'h8;
   localparam logic [3:0] MODE_PFC_CMPA = 4'h9;
   localparam logic [CNT_W-1:0] BOTTOM = 16'h0000;
   localparam logic [CNT_W-1:0] TOP_MIN = 16'h0003;
   localparam logic [CNT_W-1:0] CNT_RST = 16'h0000;
   localparam logic [3:0] FLAGS_RST = 4'h0;
   localparam logic [DIV_W-1:0] DIV1_LAST = 10'h000;
   localparam logic [DIV_W-1:0] DIV8_LAST = 10'h007;
   localparam logic [DIV_W-1:0] DIV64_LAST = 10'h03F;
   localparam logic [DIV_W-1:0] DIV256_LAST = 10'h0FF;
   localparam logic [DIV_W-1:0] DIV1024_LAST = 10'h3FF;
   typedef enum logic [1:0] {ACT_OFF = 2'b00, ACT_TOGGLE = 2'b01, ACT_NONINV = 2'b10, ACT_INV = 2'b11} dsfcp_action_e;
   typedef enum logic [2:0] {CS_STOP = 3'b000, CS_DIV1 = 3'b001, CS_DIV8 = 3'b010, CS_DIV64 = 3'b011,
      CS_DIV256 = 3'b100, CS_DIV1024 = 3'b101} dsfcp_clksel_e;
   typedef enum logic {DIR_UP = 1'b0, DIR_DOWN = 1'b1} dsfcp_dir_e;
endpackage : dsfcp_pkg

// File: inc/dsfcp_cmp_if.sv
// link between the counter core and one compare channel
`timescale 1ns/1ps
interface dsfcp_cmp_if import dsfcp_pkg::*; ();
   logic tick;
   logic upPhase;
   logic load;
   logic isChanA;
   logic [CNT_W-1:0] count;
   logic [CNT_W-1:0] top;
   logic [CNT_W-1:0] bufVal;
   logic [CNT_W-1:0] activeVal;
   dsfcp_action_e action;
   logic match;
   logic outLvl;
   modport core (output tick, upPhase, load, isChanA, count, top, bufVal, action,
      input activeVal, match, outLvl);
   modport chan (input tick, upPhase, load, isChanA, count, top, bufVal, action,
      output activeVal, match, outLvl);
endinterface : dsfcp_cmp_if

// File: hdl/dsfcp_prescaler.sv
// timer tick generator dividing the io clock
`timescale 1ns/1ps
module dsfcp_prescaler import dsfcp_pkg::*; (
   input wire logic mclk,
   input wire logic reset_n,
   input wire dsfcp_clksel_e clkSel,
   output logic tick
);
   logic [DIV_W-1:0] divCnt;
   logic [DIV_W-1:0] divLast;

   always_comb
   begin
      case (clkSel)
         CS_DIV1: divLast = DIV1_LAST;
         CS_DIV8: divLast = DIV8_LAST;
         CS_DIV64: divLast = DIV64_LAST;
         CS_DIV256: divLast = DIV256_LAST;
         CS_DIV1024: divLast = DIV1024_LAST;
         default: divLast = DIV1_LAST;
      endcase
   end

   // single pulse per period, used as an enable on mclk only
   always_ff @(posedge mclk)
   begin
      if (!reset_n || clkSel == CS_STOP || clkSel > CS_DIV1024)
      begin
         divCnt <= '0;
         tick <= 1'b0;
      end
      else if (divCnt >= divLast)
      begin
         divCnt <= '0;
         tick <= 1'b1;
      end
      else
      begin
         divCnt <= DIV_W'(divCnt + 1'b1);
         tick <= 1'b0;
      end
   end

   a_div8_gap: assert property (@(posedge mclk) disable iff (!reset_n)
      tick && clkSel == CS_DIV8 |=> (!tick || clkSel != CS_DIV8)[*7])
      else $error("tick closer than eight cycles at divide by 8");
endmodule : dsfcp_prescaler

// File: hdl/dsfcp_channel.sv
// one compare channel: double-buffered compare value and waveform output
`timescale 1ns/1ps
module dsfcp_channel import dsfcp_pkg::*; (
   input wire logic mclk,
   input wire logic reset_n,
   dsfcp_cmp_if.chan cb
);
   // never matches above top, even right after top was lowered
   assign cb.match = cb.tick && cb.count == cb.activeVal && cb.activeVal <= cb.top;

   always_ff @(posedge mclk)
   begin
      if (!reset_n)
         cb.activeVal <= CNT_RST;
      else if (cb.load)
         cb.activeVal <= cb.bufVal;
   end

   always_ff @(posedge mclk)
   begin
      if (!reset_n)
         cb.outLvl <= 1'b0;
      else if (cb.match)
      begin
         case (cb.action)
            ACT_NONINV: cb.outLvl <= !cb.upPhase;
            ACT_INV: cb.outLvl <= cb.upPhase;
            ACT_TOGGLE: cb.outLvl <= cb.isChanA ? !cb.outLvl : cb.outLvl;
            default: cb.outLvl <= cb.outLvl;
         endcase
      end
   end

   a_clear_up: assert property (@(posedge mclk) disable iff (!reset_n)
      cb.match && cb.upPhase && cb.action == ACT_NONINV |=> !cb.outLvl)
      else $error("non-inverted output not cleared on up-count match");
   a_no_match_above: assert property (@(posedge mclk) disable iff (!reset_n)
      cb.activeVal > cb.top |-> !cb.match)
      else $error("match above top");
   a_buffer_hold: assert property (@(posedge mclk) disable iff (!reset_n)
      !cb.load |=> cb.activeVal == $past(cb.activeVal))
      else $error("active compare value changed outside a load");
   a_toggle_a: assert property (@(posedge mclk) disable iff (!reset_n)
      cb.match && cb.action == ACT_TOGGLE |=> cb.outLvl == (cb.isChanA ^ $past(cb.outLvl)))
      else $error("toggle action wrong");
   c_toggle: cover property (@(posedge mclk) disable iff (!reset_n) cb.match && cb.action == ACT_TOGGLE);
endmodule : dsfcp_channel

// File: tb/dsfcp_pin_load.sv
// pin load model: pulled-down output pins with high-time counters
`timescale 1ns/1ps
module dsfcp_pin_load import dsfcp_pkg::*; (
   input wire logic mclk,
   input wire logic clrCnt,
   input wire logic [NUM_CH-1:0] compareOut,
   input wire logic [NUM_CH-1:0] compareOe,
   output logic [NUM_CH-1:0] pinLevel,
   output logic [31:0] highCntA,
   output logic [31:0] highCntB
);
   // undriven pin falls to the pull-down, it never keeps the last level
   assign pinLevel = compareOut & compareOe;
   always_ff @(posedge mclk)
   begin
      if (clrCnt)
      begin
         highCntA <= 32'h0000_0000;
         highCntB <= 32'h0000_0000;
      end
      else
      begin
         highCntA <= highCntA + {31'h0000_0000, pinLevel[0]};
         highCntB <= highCntB + {31'h0000_0000, pinLevel[1]};
      end
   end
endmodule : dsfcp_pin_load

// File: tb/tb_dual_slope_freq_correct_pwm.sv
// self-checking bench for the dual-slope frequency-correct pwm timer
`timescale 1ns/1ps
`define CHK(nm, exp, got) \
   begin \
      cmpCount++; \
      if ((got) !== (exp)) \
      begin \
         errTotal++; \
         $display("Error %s expected %0h seen %0h", nm, exp, got); \
      end \
   end
module tb_dual_slope_freq_correct_pwm import dsfcp_pkg::*;;
   typedef struct {
      logic [3:0] mode;
      logic [2:0] clk;
      logic [1:0] actA;
      logic [1:0] actB;
      logic [15:0] cmpA;
      logic [15:0] cmpB;
      logic [15:0] capt;
      logic [1:0] dir;
      int per;
      logic [31:0] hiA;
      logic [31:0] hiB;
      logic [3:0] flags;
   } dsfcp_row_s;
   localparam int LIMIT = 60000;
   logic mclk = 1'b0;
   logic reset_n = 1'b0;
   logic psel = 1'b0;
   logic penable = 1'b0;
   logic pwrite = 1'b0;
   logic [7:0] paddr = 8'h00;
   logic [31:0] pwdata = 32'h0000_0000;
   logic [31:0] prdata;
   logic pready;
   logic pslverr;
   logic [NUM_CH-1:0] compareOut;
   logic [NUM_CH-1:0] compareOe;
   logic clrCnt = 1'b0;
   logic [31:0] highCntA;
   logic [31:0] highCntB;
   int errTotal = 0;
   int cmpCount = 0;
   int cycles = 0;
   // high time over one period is 2*c*n non-inverted, 2*(top-c)*n inverted
   dsfcp_row_s rows[5] = '{
      '{4'h8, 3'h1, 2'h2, 2'h3, 16'h0002, 16'h0001, 16'h0005, 2'h3, 10, 32'h0000_0004, 32'h0000_0008, 4'hF},
      '{4'h9, 3'h2, 2'h3, 2'h2, 16'h0006, 16'h0006, 16'h0000, 2'h3, 96, 32'h0000_0000, 32'h0000_0060, 4'h7},
      '{4'h8, 3'h3, 2'h3, 2'h2, 16'h0000, 16'h0009, 16'h0003, 2'h1, 384, 32'h0000_0180, 32'h0000_0000, 4'hB},
      '{4'h8, 3'h4, 2'h1, 2'h1, 16'h0002, 16'h0001, 16'h0004, 2'h3, 2048, 32'h0000_0400, 32'h0000_0000, 4'hF},
      '{4'h9, 3'h5, 2'h2, 2'h3, 16'h0003, 16'h0001, 16'h0000, 2'h2, 6144, 32'h0000_0000, 32'h0000_1000, 4'h7}
   };
   logic [7:0] offs[7] = '{OFS_CTRL, OFS_COUNT, OFS_CMPA, OFS_CMPB, OFS_CAPT, OFS_FLAGS, OFS_PINDIR};

   dsfcp_top u_dut (.mclk(mclk), .reset_n(reset_n), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .compareOut(compareOut), .compareOe(compareOe));
   dsfcp_pin_load u_load (.mclk(mclk), .clrCnt(clrCnt), .compareOut(compareOut), .compareOe(compareOe),
      .pinLevel(), .highCntA(highCntA), .highCntB(highCntB));

   always #5 mclk = ~mclk;

   task automatic giveVerdict();
      $display("compares %0d mismatches %0d", cmpCount, errTotal);
      if (errTotal == 0 && cmpCount > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask : giveVerdict

   // request held from setup until pready is sampled high
   task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d,
      output logic [31:0] rd, output logic err);
      @(posedge mclk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge mclk);
      penable <= 1'b1;
      @(posedge mclk);
      while (pready !== 1'b1)
         @(posedge mclk);
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask : apb

   always @(posedge mclk)
   begin
      cycles++;
      if (cycles == LIMIT)
      begin
         errTotal++;
         giveVerdict();
      end
   end

   initial
   begin
      dsfcp_row_s r;
      logic [31:0] rd;
      logic [31:0] prev;
      logic err;
      logic [31:0] ctrl;
      int stepBad;
      int topReads;
      int run;
      int maxRun;
      repeat (12) @(posedge mclk);
      reset_n <= 1'b1;
      foreach (rows[i])
      begin
         r = rows[i];
         ctrl = {20'h0_0000, r.actB, r.actA, 1'b0, r.clk, r.mode};
         apb(1'b1, OFS_CTRL, 32'h0000_0000, rd, err);
         apb(1'b1, OFS_CMPA, {16'h0000, r.cmpA}, rd, err);
         apb(1'b1, OFS_CMPB, {16'h0000, r.cmpB}, rd, err);
         apb(1'b1, OFS_CAPT, {16'h0000, r.capt}, rd, err);
         apb(1'b1, OFS_PINDIR, {30'h0000_0000, r.dir}, rd, err);
         apb(1'b1, OFS_CTRL, ctrl, rd, err);
         apb(1'b0, OFS_CTRL, 32'h0000_0000, rd, err);
         `CHK("ctrl readback", ctrl, rd)
         repeat (2 * r.per + 4) @(posedge mclk);
         apb(1'b1, OFS_FLAGS, 32'h0000_000F, rd, err);
         @(posedge mclk) clrCnt <= 1'b1;
         @(posedge mclk) clrCnt <= 1'b0;
         repeat (r.per) @(posedge mclk);
         #1;
         `CHK("high time a", r.hiA, highCntA)
         `CHK("high time b", r.hiB, highCntB)
         apb(1'b0, OFS_FLAGS, 32'h0000_0000, rd, err);
         `CHK("flags", {28'h000_0000, r.flags}, rd)
      end
      // count walk: steps of one, turns at top, each value one tick of 8 cycles
      apb(1'b1, OFS_CTRL, 32'h0000_0000, rd, err);
      apb(1'b1, OFS_CMPA, 32'h0000_0004, rd, err);
      apb(1'b1, OFS_CTRL, 32'h0000_0029, rd, err);
      repeat (20) @(posedge mclk);
      apb(1'b0, OFS_COUNT, 32'h0000_0000, prev, err);
      stepBad = 0;
      topReads = 0;
      run = 1;
      maxRun = 1;
      repeat (60)
      begin
         apb(1'b0, OFS_COUNT, 32'h0000_0000, rd, err);
         if (rd > 32'h0000_0004 || (rd !== prev && rd !== prev + 1 && rd !== prev - 1))
            stepBad++;
         run = (rd === prev) ? run + 1 : 1;
         maxRun = (run > maxRun) ? run : maxRun;
         topReads += (rd === 32'h0000_0004) ? 1 : 0;
         prev = rd;
      end
      `CHK("count walk", 1'b1, stepBad == 0 && topReads > 0 && maxRun <= 3)
      // live top raise in mode 9: the old top holds until a bottom loads the buffer
      apb(1'b1, OFS_CMPA, 32'h0000_0006, rd, err);
      stepBad = 0;
      topReads = 0;
      run = 0;
      repeat (60)
      begin
         apb(1'b0, OFS_COUNT, 32'h0000_0000, rd, err);
         run = (rd === 32'h0000_0000) ? 1 : run;
         if (rd > ((run == 1) ? 32'h0000_0006 : 32'h0000_0004))
            stepBad++;
         topReads += (rd === 32'h0000_0006) ? 1 : 0;
      end
      `CHK("live top change", 1'b1, stepBad == 0 && topReads > 0)
      // a mode outside 8 and 9 keeps the counter still
      apb(1'b1, OFS_CTRL, 32'h0000_001A, rd, err);
      repeat (10) @(posedge mclk);
      apb(1'b1, OFS_COUNT, 32'h0000_0005, rd, err);
      apb(1'b0, OFS_COUNT, 32'h0000_0000, rd, err);
      `CHK("count idle mode", 32'h0000_0000, rd)
      apb(1'b0, 8'h1C, 32'h0000_0000, rd, err);
      `CHK("unmapped read err", 1'b1, err)
      `CHK("unmapped read data", 32'h0000_0000, rd)
      apb(1'b1, 8'h40, 32'h0000_00FF, rd, err);
      `CHK("unmapped write err", 1'b1, err)
      // second reset in mid-run with the pin driven
      apb(1'b1, OFS_PINDIR, 32'h0000_0003, rd, err);
      apb(1'b1, OFS_CTRL, 32'h0000_0B19, rd, err);
      repeat (30) @(posedge mclk);
      reset_n <= 1'b0;
      repeat (2) @(posedge mclk);
      reset_n <= 1'b1;
      #1;
      `CHK("oe after reset", 2'b00, compareOe)
      `CHK("out after reset", 2'b00, compareOut)
      foreach (offs[i])
      begin
         apb(1'b0, offs[i], 32'h0000_0000, rd, err);
         `CHK("reset value", 32'h0000_0000, rd)
      end
      giveVerdict();
   end
endmodule : tb_dual_slope_freq_correct_pwm
